// *** irq_sink.sv ***
// Purpose: far-side model counting transfer and dma requests
// Assumes: requests are one-cycle pulses per channel
// Notes: behavioural, accepts every request at once
`timescale 1ns/1ps
module irq_sink
  import tpu_irq_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic [2:0] dtcReq,
  input wire logic [2:0] dmaReq,
  output logic [2:0][3:0] dtcSeen,
  output logic [2:0][3:0] dmaSeen
);
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      dtcSeen <= '0;
      dmaSeen <= '0;
    end
    else
    begin
      for (int i = 0; i < NCH; i++)
      begin
        dtcSeen[i] <= dtcSeen[i] + 4'(dtcReq[i]);
        dmaSeen[i] <= dmaSeen[i] + 4'(dmaReq[i]);
      end
    end
  end
endmodule

// *** tb.sv ***
// Purpose: self-checking bench for the timer interrupt and phase block
// Assumes: one-cycle APB access, status cleared by read
// Notes: far side counted by irq_sink
`timescale 1ns/1ps
module tb
  import tpu_irq_pkg::*;
;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, irq, se;
  logic [2:0] pA = 3'h0, pB = 3'h0, chanIrq, dtcReq, dmaReq, topSource;
  logic [1:0] topChannel;
  logic [2:0][3:0] dtcSeen, dmaSeen;
  int err_total = 0;
  int num_checks = 0;
  always #12.5 clk = ~clk;
  timer_pulse_unit_irq timer_pulse_unit_irq_inst (.clk(clk), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .extClockInA(pA[1]), .extClockInB(pB[1]), .extClockInC(pA[2]), .extClockInD(pB[2]), .irq(irq),
    .chanIrq(chanIrq), .topChannel(topChannel), .topSource(topSource), .dtcReq(dtcReq), .dmaReq(dmaReq));
  irq_sink irq_sink_inst (.clk(clk), .rst(rst), .dtcReq(dtcReq), .dmaReq(dmaReq), .dtcSeen(dtcSeen),
    .dmaSeen(dmaSeen));
  task automatic test_done();
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    num_checks++;
    if (got !== exp)
    begin
      err_total++;
      $display("CHECK FAILED t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1)
      @(posedge clk);
    rd = prdata;
    se = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] exp, input string what);
    apb(1'b0, a, 32'h0);
    chk(rd, exp, what);
  endtask
  task automatic pin(input int c, input logic a, input logic b);
    @(posedge clk);
    pA[c] <= a;
    pB[c] <= b;
    repeat (6) @(posedge clk);
  endtask
  task automatic settle();
    repeat (2) @(posedge clk);
  endtask
  initial
  begin
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    rdc(OFF_ORDER, 32'h0, "order reset");
    rdc(8'h70, 32'h0, "unmapped");
    chk(32'(se), 32'h1, "unmapped error");
    for (int c = 0; c < 3; c++)
      for (int r = 0; r < 4; r++)
        apb(1'b1, {3'(c), OFF_CMP + 5'(4 * r)}, 32'h10 + 32'(r) * 32'h100);
    apb(1'b1, {3'h0, OFF_IEN}, 32'h3f);
    rdc({3'h0, OFF_IEN}, 32'h1f, "ch0 enable");
    apb(1'b1, {3'h0, OFF_CTRL}, 32'h1);
    for (int n = 0; n < 40 && irq !== 1'b1; n++)
      @(posedge clk);
    chk(32'({chanIrq, topChannel, topSource}), 32'h20, "ch0 match");
    apb(1'b1, {3'h0, OFF_CTRL}, 32'h0);
    apb(1'b1, {3'h0, OFF_STAT}, 32'h3f);
    rdc({3'h0, OFF_STAT}, 32'h1, "match flag");
    @(posedge clk);
    chk(32'(irq), 32'h0, "irq cleared");
    $display("test match done");
    apb(1'b1, {3'h1, OFF_CNT}, 32'hfffe);
    apb(1'b1, {3'h1, OFF_CTRL}, 32'h1);
    apb(1'b1, {3'h1, OFF_CTRL}, 32'h0);
    chk(32'(irq), 32'h0, "masked");
    apb(1'b1, {3'h1, OFF_IEN}, 32'h3f);
    settle();
    chk(32'({chanIrq, topChannel, topSource}), 32'h4c, "ch1 ovf");
    apb(1'b1, {3'h0, OFF_CMP}, 32'hffff);
    apb(1'b1, {3'h0, OFF_CNT}, 32'hfffe);
    apb(1'b1, {3'h0, OFF_CTRL}, 32'h1);
    apb(1'b1, {3'h0, OFF_CTRL}, 32'h0);
    chk(32'({chanIrq, topChannel, topSource}), 32'h60, "A first, ch0 first");
    apb(1'b1, OFF_ORDER, 32'h1);
    settle();
    chk(32'({topChannel, topSource}), 32'h0c, "order 1");
    apb(1'b1, OFF_ORDER, 32'h3);
    rdc(OFF_ORDER, 32'h1, "order 3 refused");
    apb(1'b1, OFF_ORDER, 32'h0);
    rdc({3'h0, OFF_STAT}, 32'h11, "ch0 flags");
    rdc({3'h1, OFF_STAT}, 32'h10, "ch1 flags");
    @(posedge clk);
    chk(32'(irq), 32'h0, "all cleared");
    $display("test priority done");
    for (int c = 1; c < 3; c++)
    begin
      apb(1'b1, {3'(c), OFF_IEN}, 32'h33);
      apb(1'b1, {3'(c), OFF_CNT}, 32'h80);
      apb(1'b1, {3'(c), OFF_CTRL}, 32'h3);
      pin(c, 1'b0, 1'b1);
      pin(c, 1'b1, 1'b1);
      rdc({3'(c), OFF_CNT}, 32'h81, "up");
      pin(c, 1'b0, 1'b1);
      rdc({3'(c), OFF_CNT}, 32'h80, "down");
      pin(c, 1'b1, 1'b0);
      rdc({3'(c), OFF_CNT}, 32'h80, "hold");
      apb(1'b1, {3'(c), OFF_CNT}, 32'h0);
      pin(c, 1'b1, 1'b1);
      pin(c, 1'b0, 1'b1);
      chk(32'(chanIrq[c]), 32'h1, "unf request");
      rdc({3'(c), OFF_STAT}, 32'h20, "unf flag");
      rdc({3'(c), OFF_CNT}, 32'hffff, "wrap");
      apb(1'b1, {3'(c), OFF_CTRL}, 32'h0);
    end
    $display("test phase done");
    apb(1'b1, {3'h0, OFF_CNT}, 32'h10f);
    apb(1'b1, {3'h0, OFF_CTRL}, 32'h1);
    apb(1'b1, {3'h0, OFF_CTRL}, 32'h0);
    rdc({3'h0, OFF_STAT}, 32'h2, "match b flag");
    chk(32'({dtcSeen, dmaSeen}), 32'h003002, "transfer requests");
    $display("test requests done");
    test_done();
  end
  initial
  begin
    #(25 * 20000);
    err_total++;
    $display("CHECK FAILED t=%0t watchdog", $time);
    test_done();
  end
endmodule

// *** timer_pulse_unit_irq.sv ***
// Purpose: three-channel timer with interrupt flags, requests and phase counting
// Assumes: APB slave, ext clock inputs asynchronous to clk
// Notes: status bits clear on read of the status register
//
// The implementer's own choices: the address map and the APB slave port.
`timescale 1ns/1ps
module timer_pulse_unit_irq
  import tpu_irq_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic extClockInA,
  input wire logic extClockInB,
  input wire logic extClockInC,
  input wire logic extClockInD,
  output logic irq,
  output logic [2:0] chanIrq,
  output logic [1:0] topChannel,
  output logic [2:0] topSource,
  output logic [2:0] dtcReq,
  output logic [2:0] dmaReq
);

  chan_t ch [NCH];
  chan_t next_ch [NCH];
  order_t order;
  order_t next_order;
  logic [3:0] pinMeta;
  logic [3:0] pinSync;
  logic [3:0] pinLast;
  logic [31:0] next_prdata;
  logic next_pready;
  logic next_pslverr;
  logic next_irq;
  logic [2:0] next_chanIrq;
  logic [1:0] next_topChannel;
  logic [2:0] next_topSource;
  logic [2:0] next_dtcReq;
  logic [2:0] next_dmaReq;
  logic setup;
  logic done;
  logic [2:0] rdClr;
  logic [2:0] wrHit;

  assign setup = psel & ~penable;
  assign done = psel & penable & pready;

  // lowest set bit wins
  function automatic logic [2:0] firstBit(input logic [5:0] v);
    logic [2:0] r;
    r = 3'd0;
    for (int k = 5; k >= 0; k--)
    begin
      if (v[k])
      begin
        r = 3'(k);
      end
    end
    return r;
  endfunction

  // external clock inputs, two-stage sync then edge history
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      pinMeta <= 4'h0;
      pinSync <= 4'h0;
      pinLast <= 4'h0;
    end
    else
    begin
      pinMeta <= {extClockInD, extClockInC, extClockInB, extClockInA};
      pinSync <= pinMeta;
      pinLast <= pinSync;
    end
  end

  always_comb
  begin
    logic [4:0] off;
    logic [1:0] idx;
    logic hit;
    logic up;
    logic down;
    logic aRise;
    logic aFall;
    logic bHigh;
    logic [15:0] newCnt;
    logic [5:0] ev;
    logic [5:0] srcMask;
    logic [5:0] pend;
    int c;
    off = paddr[4:0];
    idx = paddr[6:5];
    hit = 1'b0;
    up = 1'b0;
    down = 1'b0;
    aRise = 1'b0;
    aFall = 1'b0;
    bHigh = 1'b0;
    newCnt = 16'h0000;
    ev = 6'h00;
    srcMask = 6'h00;
    pend = 6'h00;
    c = 0;
    next_order = order;
    next_prdata = prdata;
    next_pslverr = pslverr;
    next_pready = setup & ~pready;
    rdClr = 3'b000;
    wrHit = 3'b000;
    if (paddr == OFF_ORDER)
    begin
      hit = 1'b1;
    end
    else if (paddr[7] == 1'b0 && idx != 2'd3 && paddr[1:0] == 2'b00 && off <= OFF_CMP + 5'h0c)
    begin
      hit = 1'b1;
    end
    if (setup)
    begin
      next_pslverr = ~hit;
      next_prdata = 32'h0000_0000;
      if (paddr == OFF_ORDER)
      begin
        next_prdata[1:0] = order;
      end
      else if (hit)
      begin
        case (off)
          OFF_CTRL: next_prdata[1:0] = {ch[idx].phase, ch[idx].run};
          OFF_IEN: next_prdata[5:0] = ch[idx].ien;
          OFF_STAT: next_prdata[5:0] = ch[idx].stat;
          OFF_CNT: next_prdata[15:0] = ch[idx].cnt;
          default: next_prdata[15:0] = ch[idx].cmp[off[3:2]];
        endcase
      end
    end
    for (c = 0; c < NCH; c++)
    begin
      next_ch[c] = ch[c];
      srcMask = (c == 0) ? SRC_MASK0 : SRC_MASK12; // R8 R9
      if (c > 0)
      begin
        aRise = pinSync[2 * c - 2] & ~pinLast[2 * c - 2]; // R11
        aFall = ~pinSync[2 * c - 2] & pinLast[2 * c - 2];
        bHigh = pinSync[2 * c - 1];
      end
      else
      begin
        aRise = 1'b0;
        aFall = 1'b0;
        bHigh = 1'b0;
      end
      if (ch[c].phase && c > 0)
      begin
        up = ch[c].run & aRise & bHigh; // R12
        down = ch[c].run & aFall & bHigh; // R12
      end
      else
      begin
        up = ch[c].run;
        down = 1'b0;
      end
      newCnt = up ? ch[c].cnt + 16'h0001 : (down ? ch[c].cnt - 16'h0001 : ch[c].cnt);
      ev = 6'h00;
      for (int k = 0; k < 4; k++)
      begin
        ev[k] = (up | down) & (newCnt == ch[c].cmp[k]); // R1
      end
      ev[BIT_OVF] = up & (ch[c].cnt == CNT_MAX); // R1
      ev[BIT_UNF] = down & (ch[c].cnt == CNT_MIN); // R1
      ev = ev & srcMask; // R2
      next_ch[c].cnt = newCnt;
      if (done && !pwrite && !pslverr && idx == 2'(c) && off == OFF_STAT && paddr[7:5] != 3'd3)
      begin
        rdClr[c] = 1'b1;
      end
      // set wins over read clear
      next_ch[c].stat = (ch[c].stat & ~(rdClr[c] ? prdata[5:0] : 6'h00)) | ev; // R3 R5
      if (done && pwrite && !pslverr && idx == 2'(c) && paddr[7] == 1'b0)
      begin
        wrHit[c] = 1'b1;
        case (off)
          OFF_CTRL:
          begin
            next_ch[c].run = pwdata[CTRL_RUN];
            next_ch[c].phase = (c > 0) ? pwdata[CTRL_PHASE] : 1'b0; // R11
          end
          OFF_IEN: next_ch[c].ien = pwdata[5:0] & srcMask; // R2
          OFF_STAT: next_ch[c].ien = next_ch[c].ien;
          OFF_CNT: next_ch[c].cnt = pwdata[15:0];
          default: next_ch[c].cmp[off[3:2]] = pwdata[15:0];
        endcase
      end
      next_dtcReq[c] = |ev[3:0]; // R10
      next_dmaReq[c] = ev[BIT_A]; // R10
      next_chanIrq[c] = |(next_ch[c].stat & next_ch[c].ien); // R4 R5
    end
    if (done && pwrite && paddr == OFF_ORDER && pwdata[1:0] != 2'd3)
    begin
      next_order = order_t'(pwdata[1:0]); // R7
    end
    next_irq = |next_chanIrq; // R4
    next_topChannel = 2'd0;
    next_topSource = 3'd0;
    for (int r = 2; r >= 0; r--)
    begin
      case (next_order)
        ORD_120: c = (r + 1) % NCH; // R7
        ORD_201: c = (r + 2) % NCH;
        default: c = r;
      endcase
      pend = next_ch[c].stat & next_ch[c].ien;
      if (|pend)
      begin
        next_topChannel = 2'(c);
        next_topSource = firstBit(pend); // R6
      end
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      for (int c = 0; c < NCH; c++)
      begin
        ch[c] <= '0;
      end
      order <= ORD_012; // R7
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
      irq <= 1'b0;
      chanIrq <= 3'b000;
      topChannel <= 2'd0;
      topSource <= 3'd0;
      dtcReq <= 3'b000;
      dmaReq <= 3'b000;
    end
    else
    begin
      for (int c = 0; c < NCH; c++)
      begin
        ch[c] <= next_ch[c];
      end
      order <= next_order;
      prdata <= next_prdata;
      pready <= next_pready;
      pslverr <= next_pslverr;
      irq <= next_irq;
      chanIrq <= next_chanIrq;
      topChannel <= next_topChannel;
      topSource <= next_topSource;
      dtcReq <= next_dtcReq;
      dmaReq <= next_dmaReq;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  AST_IRQ_ANY: assert property (irq == |chanIrq) // R4
    else $error("irq differs from channel requests");
  AST_CH1_REQ: assert property (chanIrq[1] == |(ch[1].stat & ch[1].ien)) // R4
    else $error("channel 1 request wrong");
  AST_FLAG_HOLD: assert property ($fell(ch[0].stat[BIT_A]) |-> $past(rdClr[0])) // R5
    else $error("flag dropped without status read");
  AST_DMA_FLAG: assert property (dmaReq[2] |-> ch[2].stat[BIT_A] && dtcReq[2]) // R3
    else $error("dma request without match A flag");
  AST_NO_UNF0: assert property (ch[0].stat[BIT_UNF] == 1'b0) // R8
    else $error("channel 0 underflow flag set");
  AST_NO_CD12: assert property (ch[1].stat[3:2] == 2'b00 && ch[2].stat[3:2] == 2'b00) // R9
    else $error("channel 1/2 flag C or D set");
  AST_OVF0: assert property (ch[0].run && ch[0].cnt == CNT_MAX && !wrHit[0] |=> ch[0].stat[BIT_OVF]) // R1
    else $error("overflow not flagged");
  AST_PHASE_HOLD: assert property (ch[1].phase && pinSync[0] == pinLast[0] && !wrHit[1] |=> $stable(ch[1].cnt)) // R12
    else $error("phase count moved without edge");
  AST_PHASE_UP: assert property (ch[2].run && ch[2].phase && pinSync[2] && !pinLast[2] && pinSync[3]
    && !wrHit[2] |=> ch[2].cnt == $past(ch[2].cnt) + 16'h0001) // R11
    else $error("phase up-count missing");
  AST_ORDER_TOP: assert property (order == ORD_012 && chanIrq[0] |-> topChannel == 2'd0) // R7
    else $error("channel 0 not on top");
  AST_SRC_TOP: assert property (chanIrq[0] && topChannel == 2'd0 && ch[0].stat[BIT_A] && ch[0].ien[BIT_A] // R6
    |-> topSource == 3'd0)
    else $error("match A not highest source");
  AST_READY: assert property (setup && !pready |=> pready ##1 !pready) // R2
    else $error("apb ready timing");

  AST_DTC_SRC: assert property (dtcReq[0] |-> |ch[0].stat[3:0]) // R10
    else $error("transfer request without match flag");
  AST_DTC_NO_OVF: assert property (dtcReq[2] |-> |ch[2].stat[1:0]) // R10
    else $error("transfer request from overflow or underflow");
  AST_DMA_ONLY_A: assert property (dmaReq[1] |-> ch[1].stat[BIT_A] && dtcReq[1]) // R10
    else $error("dma request without match A flag");
  AST_FLAG_HOLD2: assert property ($fell(ch[2].stat[BIT_UNF]) |-> $past(rdClr[2])) // R5
    else $error("underflow flag dropped without status read");
  AST_OVF_FROM_MAX: assert property ($rose(ch[1].stat[BIT_OVF]) |-> $past(ch[1].cnt) == CNT_MAX) // R1
    else $error("overflow flag without counter at maximum");
  AST_UNF_FROM_MIN: assert property ($rose(ch[2].stat[BIT_UNF]) |-> $past(ch[2].cnt) == CNT_MIN) // R1
    else $error("underflow flag without counter at zero");
  AST_MATCH_A0: assert property ($rose(ch[0].stat[BIT_A]) |-> $past(wrHit[0]) || ch[0].cnt == ch[0].cmp[0]) // R3
    else $error("match A flag without counter match");
  AST_IRQ_NONE: assert property (!irq |-> topChannel == 2'd0 && topSource == 3'd0) // R4
    else $error("top source shown without request");
  AST_TOP_PEND: assert property (irq |-> chanIrq[topChannel]) // R7
    else $error("top channel has no request");
  AST_ORDER_LEGAL: assert property (2'(order) != 2'd3) // R7
    else $error("channel order holds refused value");
  AST_CH0_PHASE: assert property (!ch[0].phase) // R11
    else $error("channel 0 in phase mode");
  AST_IEN_MASK: assert property ((ch[0].ien & ~SRC_MASK0) == 6'h00 && (ch[2].ien & ~SRC_MASK12) == 6'h00) // R2
    else $error("enable bit set for missing source");
  AST_STAT_MASK: assert property ((ch[0].stat & ~SRC_MASK0) == 6'h00 && (ch[1].stat & ~SRC_MASK12) == 6'h00) // R8 R9
    else $error("flag set for missing source");
  AST_CH0_REQ: assert property (chanIrq[0] == |(ch[0].stat & ch[0].ien)) // R4
    else $error("channel 0 request wrong");
  AST_CH2_REQ: assert property (chanIrq[2] == |(ch[2].stat & ch[2].ien)) // R4
    else $error("channel 2 request wrong");
  AST_SRC_TOP1: assert property (topChannel == 2'd1 && chanIrq[1] && ch[1].stat[BIT_OVF] // R6
    && ch[1].ien[BIT_OVF] && ch[1].stat[1:0] == 2'b00 |-> topSource == 3'd4)
    else $error("overflow not top source of channel 1");
  AST_PHASE_DOWN: assert property (ch[1].run && ch[1].phase && !pinSync[0] && pinLast[0] && pinSync[1] // R12
    && !wrHit[1] |=> ch[1].cnt == $past(ch[1].cnt) - 16'h0001)
    else $error("phase down-count missing");
  AST_PHASE_B_LOW: assert property (ch[2].phase && !pinSync[3] && !wrHit[2] |=> $stable(ch[2].cnt)) // R12
    else $error("phase count moved with second input low");
  AST_ERR_ZERO: assert property (pready && pslverr |-> prdata == 32'h0000_0000) // R2
    else $error("refused access returned data");

  COV_DMA: cover property (dmaReq[1]);
  COV_UNF: cover property (ch[2].stat[BIT_UNF] && chanIrq[2]);
  COV_CLEAR: cover property (irq ##1 rdClr[0] ##1 !irq);
  COV_PHASE_UNF: cover property (ch[1].phase && ch[1].stat[BIT_UNF]);
  COV_ORDER: cover property (order == ORD_120 && topChannel == 2'd1 && irq);

endmodule

// *** tpu_irq_pkg.sv ***
// Purpose: constants and types of the timer pulse unit interrupt and phase block
// Assumes: one clock, APB register access, 32-bit data
// Notes: each channel occupies a 32-byte window of registers
// Contract
// R1: events are match, overflow and underflow
// R2: each event has own flag and enable
// R3: event sets its status flag
// R4: request while flag and enable set
// R5: request holds until flag cleared
// R6: fixed order: A, B, C, D, overflow, underflow
// R7: channel order adjustable, reset 0>1>2
// R8: channel 0: A-D and overflow, no underflow
// R9: channels 1,2: A, B, overflow, underflow
// R10: matches reach transfer unit; only A reaches DMA
// R11: phase mode 2 counts from input pairs
// R12: only first input edges move count
package tpu_irq_pkg;
  localparam int NCH = 3;
  localparam int CH_SHIFT = 5;
  localparam logic [4:0] OFF_CTRL = 5'h00;
  localparam logic [4:0] OFF_IEN = 5'h04;
  localparam logic [4:0] OFF_STAT = 5'h08;
  localparam logic [4:0] OFF_CNT = 5'h0c;
  localparam logic [4:0] OFF_CMP = 5'h10;
  localparam logic [7:0] OFF_ORDER = 8'h60;
  localparam int CTRL_RUN = 0;
  localparam int CTRL_PHASE = 1;
  localparam int BIT_A = 0;
  localparam int BIT_OVF = 4;
  localparam int BIT_UNF = 5;
  localparam logic [5:0] SRC_MASK0 = 6'h1f;
  localparam logic [5:0] SRC_MASK12 = 6'h33;
  localparam logic [15:0] CNT_MAX = 16'hffff;
  localparam logic [15:0] CNT_MIN = 16'h0000;
  typedef enum logic [1:0] {ORD_012, ORD_120, ORD_201} order_t;
  typedef struct packed {
    logic phase;
    logic run;
    logic [5:0] ien;
    logic [5:0] stat;
    logic [15:0] cnt;
    logic [3:0][15:0] cmp;
  } chan_t;
endpackage
